// >>> sram_cap_pkg.sv
package sram_cap_pkg;

  // ----------------------------------------------------------------
  // widths and configurations
  // ----------------------------------------------------------------
  localparam int MAX_DATA_W   = 36;
  localparam int DATA_W_DEF   = 36;
  localparam int BYTE_LANE_W  = 9;
  localparam int NIBBLE_W     = 4;
  localparam int AW_NARROW    = 21;
  localparam int AW_MID       = 20;
  localparam int AW_WIDE      = 19;
  localparam int FIFO_DEPTH_DEF = 16;

  // ----------------------------------------------------------------
  // phase of the input clock pair, one mclk cycle each
  // ----------------------------------------------------------------
  localparam logic PH_K  = 1'b0;
  localparam logic PH_KN = 1'b1;
  localparam logic PH_RESET = PH_K;

  // write sequence: first beat on the true edge, second on the complement
  typedef enum logic [0:0] {
    WR_IDLE   = 1'b0,
    WR_SECOND = 1'b1
  } wr_st_t;

  // address width per data width
  function automatic int addr_w(input int dw);
    if (dw == 36) begin
      return AW_WIDE;
    end else if (dw == 18) begin
      return AW_MID;
    end
    return AW_NARROW;
  endfunction

  // per-bit write enables from the active-low masks
  function automatic logic [MAX_DATA_W-1:0] lane_en(input int dw,
                                                    input logic [1:0] nib_n,
                                                    input logic [3:0] byt_n);
    logic [MAX_DATA_W-1:0] en;
    en = '0;
    for (int i = 0; i < MAX_DATA_W; i++) begin
      if (i < dw) begin
        if (dw == 8) begin
          en[i] = ~nib_n[i / NIBBLE_W];
        end else begin
          en[i] = ~byt_n[i / BYTE_LANE_W];
        end
      end
    end
    return en;
  endfunction

endpackage

// >>> stream_if.sv
`timescale 1ns/1ps
interface stream_if #(
  parameter int WIDTH = 8
);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;

  modport src (
    output data,
    output valid,
    input  ready
  );
  modport snk (
    input  data,
    input  valid,
    output ready
  );
endinterface

// >>> stream_fifo.sv
`timescale 1ns/1ps
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)(
  input wire logic mclk,
  input wire logic rst_n,
  stream_if.snk    fill,
  stream_if.src    drain
);
  localparam int PTR_W = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W:0]   wr_ptr_q;
  logic [PTR_W:0]   rd_ptr_q;
  logic             full;
  logic             empty;
  logic             do_wr;
  logic             do_rd;

  // extra pointer bit tells full from empty
  assign empty = (wr_ptr_q == rd_ptr_q);
  assign full  = (wr_ptr_q[PTR_W] != rd_ptr_q[PTR_W]) &&
                 (wr_ptr_q[PTR_W-1:0] == rd_ptr_q[PTR_W-1:0]);
  assign fill.ready  = ~full;
  assign drain.valid = ~empty;
  assign drain.data  = mem_q[rd_ptr_q[PTR_W-1:0]];
  assign do_wr = fill.valid & ~full;
  assign do_rd = drain.ready & ~empty;

  // storage, no reset needed for data
  always_ff @(posedge mclk) begin
    if (do_wr) begin
      mem_q[wr_ptr_q[PTR_W-1:0]] <= fill.data;
    end
  end

  // pointers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

endmodule

// >>> sram_write_port_capture.sv
// Functional notes
// - write select low, sampled on true clock edge, starts a write.
// - write select high deselects the port; data inputs are ignored.
// - x8: two nibble masks sampled on both edges pick stored nibbles.
// - a nibble with inactive mask leaves memory contents unchanged.
// - up to four byte masks sampled on both edges pick stored bytes.
// - byte mask n governs bits 9n+8 down to 9n.
// - each mask arrives with the data word it qualifies.
// - inactive byte mask discards its byte; memory byte stays unchanged.
// - address taken as read address on true edge, write address on complement.
// - storage is two equal arrays; every access moves two words.
// - address width 21 for x8/x9, 20 for x18, 19 for x36.
// - address ignored on an edge whose port is deselected.
// - read select low on true edge starts a two-word read.
`timescale 1ns/1ps
module sram_write_port_capture #(
  parameter int DATA_W     = sram_cap_pkg::DATA_W_DEF,
  parameter int MEM_AW     = sram_cap_pkg::addr_w(DATA_W),
  parameter int FIFO_DEPTH = sram_cap_pkg::FIFO_DEPTH_DEF
)(
  input  wire logic                                   mclk,
  input  wire logic                                   rst_n,
  input  wire logic                                   write_port_select_n,
  input  wire logic                                   read_port_select_n,
  input  wire logic [1:0]                             nibble_write_mask_n,
  input  wire logic [3:0]                             byte_write_mask_n,
  input  wire logic [sram_cap_pkg::addr_w(DATA_W)-1:0] addr,
  input  wire logic [DATA_W-1:0]                      wdata,
  output logic                                        k_phase_q,
  output logic                                        write_ready_q,
  output logic                                        overrun_q,
  output logic                                        rd_valid_q,
  output logic [DATA_W-1:0]                           rd_data0_q,
  output logic [DATA_W-1:0]                           rd_data1_q
);
  import sram_cap_pkg::*;

  localparam int AW = addr_w(DATA_W);
  localparam int EW = AW + 4 * DATA_W;
  localparam int PW = 8 + AW + DATA_W;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (!(DATA_W == 8 || DATA_W == 9 || DATA_W == 18 || DATA_W == 36)) begin : g_bad_w
    $error("data width must be 8, 9, 18 or 36");
  end
  if (MEM_AW < 1 || MEM_AW > AW) begin : g_bad_aw
    $error("memory address width must lie between 1 and the bus width");
  end

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  logic [PW-1:0]     pin_bus;
  logic [PW-1:0]     sync1_q;
  logic [PW-1:0]     sync2_q;
  logic              wps_s;
  logic              rps_s;
  logic [1:0]        nib_s;
  logic [3:0]        byt_s;
  logic [AW-1:0]     addr_s;
  logic [DATA_W-1:0] data_s;
  logic [DATA_W-1:0] en_now;

  assign pin_bus = {write_port_select_n, read_port_select_n, nibble_write_mask_n,
                    byte_write_mask_n, addr, wdata};

  // all pins share one delay so masks stay aligned with their data word
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else begin
      sync1_q <= pin_bus;
      sync2_q <= sync1_q;
    end
  end

  assign {wps_s, rps_s, nib_s, byt_s, addr_s, data_s} = sync2_q;
  // masks decoded together with the word sampled on the same edge;
  // a call result cannot be sliced, so the full-width lanes land here first
  logic [MAX_DATA_W-1:0] en_all;
  assign en_all = lane_en(DATA_W, nib_s, byt_s);
  assign en_now = en_all[DATA_W-1:0];

  // ----------------------------------------------------------------
  // clock phase: even cycles are the true edge, odd the complement
  // ----------------------------------------------------------------
  // the two-stage delay keeps parity, so a pin value presented while
  // k_phase_q shows a phase is processed in that same phase
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      k_phase_q <= PH_RESET;
    end else begin
      k_phase_q <= ~k_phase_q;
    end
  end

  // ----------------------------------------------------------------
  // write capture
  // ----------------------------------------------------------------
  wr_st_t            wr_st_q;
  logic [DATA_W-1:0] beat0_data_q;
  logic [DATA_W-1:0] beat0_en_q;
  logic              wr_push;

  stream_if #(.WIDTH(EW)) wr_in ();
  stream_if #(.WIDTH(EW)) wr_out ();

  // write starts only on a true edge with the select low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_st_q <= WR_IDLE;
    end else begin
      unique case (wr_st_q)
        WR_IDLE: begin
          if (k_phase_q == PH_K && !wps_s) begin
            wr_st_q <= WR_SECOND;
          end
        end
        WR_SECOND: begin
          wr_st_q <= WR_IDLE;
        end
      endcase
    end
  end

  // first beat and its masks; a deselected port leaves them untouched
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      beat0_data_q <= '0;
      beat0_en_q   <= '0;
    end else if (k_phase_q == PH_K && !wps_s) begin
      beat0_data_q <= data_s;
      beat0_en_q   <= en_now;
    end
  end

  // second beat, masks and write address go in together on the complement
  assign wr_push      = (wr_st_q == WR_SECOND) && (k_phase_q == PH_KN);
  assign wr_in.valid  = wr_push;
  assign wr_in.data   = {addr_s, beat0_data_q, beat0_en_q, data_s, en_now};

  // a push into a full buffer is lost; flag it until reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_q <= 1'b0;
    end else if (wr_push && !wr_in.ready) begin
      overrun_q <= 1'b1;
    end
  end

  // buffer state for the controller, one cycle late
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      write_ready_q <= 1'b0;
    end else begin
      write_ready_q <= wr_in.ready;
    end
  end

  stream_fifo #(
    .WIDTH (EW),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .mclk  (mclk),
    .rst_n (rst_n),
    .fill  (wr_in),
    .drain (wr_out)
  );

  // ----------------------------------------------------------------
  // two storage arrays, one word of each burst in each
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem0_q [1 << MEM_AW];
  logic [DATA_W-1:0] mem1_q [1 << MEM_AW];
  logic [AW-1:0]     dr_addr;
  logic [DATA_W-1:0] dr_d0;
  logic [DATA_W-1:0] dr_en0;
  logic [DATA_W-1:0] dr_d1;
  logic [DATA_W-1:0] dr_en1;
  logic [MEM_AW-1:0] dr_a;
  logic              drain_fire;
  logic              rd_req_q;
  logic [AW-1:0]     rd_addr_q;

  assign {dr_addr, dr_d0, dr_en0, dr_d1, dr_en1} = wr_out.data;
  assign dr_a = dr_addr[MEM_AW-1:0];
  // arrays are single ported: a pending read holds the drain off,
  // which is what lets the buffer fill under heavy read traffic
  assign wr_out.ready = ~rd_req_q;
  assign drain_fire   = wr_out.valid & ~rd_req_q;

  // masked bits keep their old contents
  always_ff @(posedge mclk) begin
    if (drain_fire) begin
      mem0_q[dr_a] <= (mem0_q[dr_a] & ~dr_en0) | (dr_d0 & dr_en0);
      mem1_q[dr_a] <= (mem1_q[dr_a] & ~dr_en1) | (dr_d1 & dr_en1);
    end
  end

  // ----------------------------------------------------------------
  // read address capture and burst fetch
  // ----------------------------------------------------------------
  // no forwarding: a read of a word still in the buffer sees old data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_req_q  <= 1'b0;
      rd_addr_q <= '0;
    end else begin
      rd_req_q <= (k_phase_q == PH_K) && !rps_s;
      if (k_phase_q == PH_K && !rps_s) begin
        rd_addr_q <= addr_s;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid_q <= 1'b0;
      rd_data0_q <= '0;
      rd_data1_q <= '0;
    end else begin
      rd_valid_q <= rd_req_q;
      if (rd_req_q) begin
        rd_data0_q <= mem0_q[rd_addr_q[MEM_AW-1:0]];
        rd_data1_q <= mem1_q[rd_addr_q[MEM_AW-1:0]];
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions and covers
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  AST_PHASE_ALT: assert property (
    (k_phase_q == PH_K) |=> (k_phase_q == PH_KN) ##1 (k_phase_q == PH_K))
    else $error("clock phase failed to alternate");

  AST_WR_START: assert property (
    (k_phase_q == PH_K && !wps_s) |=> wr_push)
    else $error("selected write did not reach the buffer");

  AST_WR_DESEL: assert property (
    (k_phase_q == PH_K && wps_s) |=> !wr_push)
    else $error("deselected write port pushed data");

  AST_WADDR: assert property (
    wr_push |-> (k_phase_q == PH_KN) && (wr_in.data[EW-1 -: AW] == addr_s))
    else $error("write address not taken on the complement edge");

  AST_MASK_BEAT1: assert property (
    wr_push |-> (wr_in.data[DATA_W-1:0] == en_now) &&
                (wr_in.data[2*DATA_W-1 -: DATA_W] == data_s))
    else $error("second beat masks not paired with their word");

  AST_MASK_BEAT0: assert property (
    wr_push |-> (wr_in.data[3*DATA_W-1 -: DATA_W] == $past(en_now)) &&
                (wr_in.data[4*DATA_W-1 -: DATA_W] == $past(data_s)))
    else $error("first beat masks not paired with their word");

  AST_LANE_MAP: assert property (
    (en_now[0] == (DATA_W == 8 ? ~nib_s[0] : ~byt_s[0])) &&
    (en_now[DATA_W-1] == (DATA_W == 8 ? ~nib_s[1] : ~byt_s[(DATA_W-1)/BYTE_LANE_W])))
    else $error("mask lane mapping wrong");

  AST_KEEP: assert property (
    drain_fire |=> ((mem0_q[$past(dr_a)] & ~$past(dr_en0)) ==
                    ($past(mem0_q[dr_a]) & ~$past(dr_en0))))
    else $error("masked bits of a stored word changed");

  AST_STORE: assert property (
    drain_fire |=> ((mem1_q[$past(dr_a)] & $past(dr_en1)) ==
                    ($past(dr_d1) & $past(dr_en1))))
    else $error("enabled bits of the second word not stored");

  AST_RD_BURST: assert property (
    (k_phase_q == PH_K && !rps_s) |-> ##2 rd_valid_q)
    else $error("selected read returned no burst");

  AST_RD_DESEL: assert property (
    (k_phase_q == PH_K && rps_s) |-> ##2 !rd_valid_q)
    else $error("deselected read returned a burst");

  AST_RADDR: assert property (
    (k_phase_q == PH_K && !rps_s) |=> rd_req_q && (rd_addr_q == $past(addr_s)))
    else $error("read address not taken on the true edge");

  AST_OVR_SET: assert property (
    (wr_push && !wr_in.ready) |=> overrun_q)
    else $error("dropped write burst not flagged");

  COV_WRITE: cover property (wr_push && wr_in.ready);
  COV_READ: cover property (rd_req_q ##1 rd_valid_q);
  COV_STALL: cover property (wr_out.valid && rd_req_q);
  COV_OVERRUN: cover property (wr_push && !wr_in.ready);

endmodule

// >>> mem_ctrl_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// controller side: pairs of true/complement cycles on shared pins
// ----------------------------------------------------------------
module mem_ctrl_model #(
  parameter int DW = 36,
  parameter int AW = 19
)(
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic          k_phase_q,
  input  wire logic          wr_req,
  input  wire logic          rd_req,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [AW-1:0] rd_addr,
  input  wire logic [DW-1:0] d0,
  input  wire logic [DW-1:0] d1,
  input  wire logic [3:0]    m0,
  input  wire logic [3:0]    m1,
  output logic               write_port_select_n,
  output logic               read_port_select_n,
  output logic [AW-1:0]      addr,
  output logic [DW-1:0]      wdata,
  output logic [3:0]         byte_write_mask_n
);
  logic          wr_q;
  logic [AW-1:0] wa_q;
  logic [DW-1:0] d1_q;
  logic [3:0]    m1_q;

  // idle pins start inactive
  initial begin
    write_port_select_n = 1'b1;
    read_port_select_n  = 1'b1;
    addr                = '0;
    wdata               = '0;
    byte_write_mask_n   = 4'hf;
    wr_q                = 1'b0;
  end

  // unused lines flip every cycle so stale values never look valid
  always @(posedge mclk) begin
    if (!rst_n) begin
      write_port_select_n <= 1'b1;
      read_port_select_n  <= 1'b1;
      wr_q                <= 1'b0;
    end else if (k_phase_q) begin
      write_port_select_n <= ~wr_req;
      read_port_select_n  <= ~rd_req;
      addr                <= rd_req ? rd_addr : ~addr;
      wdata               <= wr_req ? d0 : ~wdata;
      byte_write_mask_n   <= wr_req ? m0 : ~byte_write_mask_n;
      wr_q                <= wr_req;
      wa_q                <= wr_addr;
      d1_q                <= d1;
      m1_q                <= m1;
    end else begin
      // selects toggle here: the device must not sample them now
      write_port_select_n <= ~write_port_select_n;
      read_port_select_n  <= ~read_port_select_n;
      addr                <= wr_q ? wa_q : ~addr;
      wdata               <= wr_q ? d1_q : ~wdata;
      byte_write_mask_n   <= wr_q ? m1_q : ~byte_write_mask_n;
    end
  end
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
  import sram_cap_pkg::*;
  localparam int DW  = DATA_W_DEF;
  localparam int AW  = AW_WIDE;
  localparam int MAW = 4;

  logic          mclk;
  logic          rst_n;
  logic          wps_n;
  logic          rps_n;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [3:0]    bmask_n;
  logic          k_phase_q;
  logic          write_ready_q;
  logic          overrun_q;
  logic          rd_valid_q;
  logic [DW-1:0] rd_data0_q;
  logic [DW-1:0] rd_data1_q;
  logic          wr_req;
  logic          rd_req;
  logic [AW-1:0] wr_addr;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] d0;
  logic [DW-1:0] d1;
  logic [3:0]    m0;
  logic [3:0]    m1;
  logic [DW-1:0] mem0 [16];
  logic [DW-1:0] mem1 [16];
  logic [2*DW-1:0] expq [$];
  logic [2*DW-1:0] exp_v;
  int            failures;
  int            compares;
  int            cycles;
  int            live;
  logic          k_prev;
  integer        seed;

  sram_write_port_capture #(.DATA_W(DW), .MEM_AW(MAW), .FIFO_DEPTH(16)) u_sram_write_port_capture (
    .mclk(mclk), .rst_n(rst_n), .write_port_select_n(wps_n), .read_port_select_n(rps_n),
    .nibble_write_mask_n(2'h3), .byte_write_mask_n(bmask_n), .addr(addr), .wdata(wdata),
    .k_phase_q(k_phase_q), .write_ready_q(write_ready_q), .overrun_q(overrun_q),
    .rd_valid_q(rd_valid_q), .rd_data0_q(rd_data0_q), .rd_data1_q(rd_data1_q));

  mem_ctrl_model #(.DW(DW), .AW(AW)) u_mem_ctrl_model (
    .mclk(mclk), .rst_n(rst_n), .k_phase_q(k_phase_q), .wr_req(wr_req), .rd_req(rd_req),
    .wr_addr(wr_addr), .rd_addr(rd_addr), .d0(d0), .d1(d1), .m0(m0), .m1(m1),
    .write_port_select_n(wps_n), .read_port_select_n(rps_n), .addr(addr), .wdata(wdata),
    .byte_write_mask_n(bmask_n));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    if (failures == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      failures++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask

  function automatic logic [DW-1:0] rnd();
    logic [63:0] t;
    t = {$random(seed), $random(seed)};
    return t[DW-1:0];
  endfunction

  // upper bits are junk: only the low bits select a word
  function automatic logic [AW-1:0] rnd_addr(input int idx);
    logic [31:0] t;
    t = $random(seed);
    return {t[AW-MAW-1:0], idx[MAW-1:0]};
  endfunction

  // expected word after a masked write
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] d,
                                          input logic [3:0] m_n);
    logic [DW-1:0] r;
    r = old;
    for (int i = 0; i < DW; i++) begin
      if (!m_n[i / BYTE_LANE_W]) begin
        r[i] = d[i];
      end
    end
    return r;
  endfunction

  // one true/complement pair; requests settle mid-cycle before the partner samples
  task automatic slot(input logic w, input logic r, input int wa, input int ra,
                      input logic [3:0] ma, input logic [3:0] mb);
    logic [DW-1:0] x0;
    logic [DW-1:0] x1;
    x0 = rnd();
    x1 = rnd();
    do @(negedge mclk); while (k_phase_q !== 1'b1);
    if (r) begin
      expq.push_back({mem0[ra], mem1[ra]});
    end
    if (w) begin
      mem0[wa] = merge(mem0[wa], x0, ma);
      mem1[wa] = merge(mem1[wa], x1, mb);
    end
    wr_req  = w;
    rd_req  = r;
    wr_addr = rnd_addr(wa);
    rd_addr = rnd_addr(ra);
    d0      = x0;
    d1      = x1;
    m0      = ma;
    m1      = mb;
  endtask

  // ----------------------------------------------------------------
  // clock, read monitor and hang guard
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // outputs are looked at mid-cycle, where they have settled
  always @(negedge mclk) begin
    cycles++;
    if (rst_n !== 1'b1) begin
      live = 0;
    end else if (live < 2) begin
      live++;
    end
    if (live == 2) begin
      check(k_phase_q === ~k_prev, "clock phase did not alternate");
    end
    k_prev = k_phase_q;
    if (rst_n === 1'b1 && rd_valid_q === 1'b1) begin
      if (expq.size() == 0) begin
        check(1'b0, "read burst without a selected read");
      end else begin
        exp_v = expq.pop_front();
        check({rd_data0_q, rd_data1_q} === exp_v, "read burst data");
      end
    end
    if (cycles > 6000) begin
      failures++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed     = 32'h838a;
    failures = 0;
    compares = 0;
    cycles   = 0;
    live     = 0;
    k_prev   = 1'b0;
    rst_n    = 1'b0;
    {wr_req, rd_req, wr_addr, rd_addr, d0, d1, m0, m1} = '0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    // fill every word with all lanes on, since storage powers up unknown
    for (int i = 0; i < 16; i++) begin
      slot(1'b1, 1'b0, i, 0, 4'h0, 4'h0);
    end
    repeat (6) slot(1'b0, 1'b0, 0, 0, 4'h0, 4'h0);
    // write one half while reading the other; random deselects and lane masks
    for (int r = 0; r < 8; r++) begin
      for (int j = 0; j < 8; j++) begin
        if (j == 0) begin
          slot(1'b1, 1'b1, (r % 2) * 8, 8 - (r % 2) * 8, 4'hf, 4'hf);
        end else begin
          slot(($random(seed) & 3) != 0, ($random(seed) & 3) != 0, (r % 2) * 8 + j,
               8 - (r % 2) * 8 + j, 4'($random(seed)), 4'($random(seed)));
        end
      end
      repeat (4) slot(1'b0, 1'b0, 0, 0, 4'h0, 4'h0);
    end
    // read everything back once more
    for (int i = 0; i < 16; i++) begin
      slot(1'b0, 1'b1, 0, i, 4'h0, 4'h0);
    end
    repeat (6) slot(1'b0, 1'b0, 0, 0, 4'h0, 4'h0);
    check(expq.size() == 0, "missing read bursts");
    check(write_ready_q === 1'b1, "buffer not ready when idle");
    check(overrun_q === 1'b0, "write burst dropped");
    conclude();
  end
endmodule
